// *** hdl/adct_pkg.sv ***
// Shared constants and carrier types for the conversion trigger control block
`default_nettype none
package adct_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int CLK_PERIOD_NS      = 10;
   localparam int AUTO_SAMPLE_NS     = 200;
   localparam int AUTO_SAMPLE_CYCLES = (AUTO_SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   ////////////////////////////////////////////////////////////////////////////
   // Bus and register map (byte addresses)
   localparam int          ADDR_W        = 4;
   localparam int          DATA_W        = 32;
   localparam int          REG_W         = 16;
   localparam logic [3:0]  CTRL_OFFSET   = 4'h0;
   localparam logic [3:0]  STATUS_OFFSET = 4'h4;
   localparam logic [3:0]  COUNT_OFFSET  = 4'h8;
   localparam logic [15:0] CTRL_RESET    = 16'h0000;
   localparam logic [15:0] COUNT_RESET   = 16'h0000;

   ////////////////////////////////////////////////////////////////////////////
   // Control word fields
   localparam int ON_BIT         = 15;
   localparam int IDLE_STOP_BIT  = 13;
   localparam int RES_BIT        = 10;
   localparam int FMT_LSB        = 8;
   localparam int SRC_LSB        = 4;
   localparam int AUTO_BIT       = 2;
   localparam int SAMPLE_BIT     = 1;
   localparam int DONE_BIT       = 0;

   // Status word fields
   localparam int STAT_SAMPLING_BIT   = 0;
   localparam int STAT_CONVERTING_BIT = 1;
   localparam int STAT_HALTED_BIT     = 2;

   ////////////////////////////////////////////////////////////////////////////
   // Trigger source codes; 4'hd..4'hf are reserved
   localparam logic [3:0] SRC_MANUAL       = 4'h0;
   localparam logic [3:0] SRC_EXT_INT_ZERO = 4'h1;
   localparam logic [3:0] SRC_MULTI_ONE    = 4'h2;
   localparam logic [3:0] SRC_SINGLE_FIVE  = 4'h3;
   localparam logic [3:0] SRC_CHARGE_TIME  = 4'h4;
   localparam logic [3:0] SRC_TIMER_ONE    = 4'h5;
   localparam logic [3:0] SRC_TIMER_SLEEP  = 4'h6;
   localparam logic [3:0] SRC_AUTO_COUNT   = 4'h7;
   localparam logic [3:0] SRC_CELL_ONE     = 4'h8;
   localparam logic [3:0] SRC_MULTI_TWO    = 4'h9;
   localparam logic [3:0] SRC_MULTI_THREE  = 4'ha;
   localparam logic [3:0] SRC_SINGLE_FOUR  = 4'hb;
   localparam logic [3:0] SRC_CELL_TWO     = 4'hc;

   ////////////////////////////////////////////////////////////////////////////
   // Carriers
   typedef struct packed {
      logic cellOne;
      logic cellTwo;
      logic singleFour;
      logic singleFive;
      logic multiOne;
      logic multiTwo;
      logic multiThree;
      logic timerOne;
      logic timerOneSleep;
      logic chargeTime;
      logic extIntZero;
   } adct_events_type;

   typedef struct packed {
      logic sleepMode;
      logic idleMode;
   } adct_power_type;

   typedef struct packed {
      logic       converterOn;
      logic       stopWhenIdle;
      logic       resolutionSelect;
      logic [1:0] resultFormat;
      logic [3:0] triggerSourceSelect;
      logic       autoSample;
   } adct_ctrl_type;

endpackage
`default_nettype wire

// *** hdl/adct_trigger_select.sv ***
// Trigger source selector and auto-convert sample counter
`timescale 1ns/1ns
`default_nettype none
module adct_trigger_select #(
   parameter int SAMPLE_CYCLES = adct_pkg::AUTO_SAMPLE_CYCLES
) (
   input  wire logic                      clk,
   input  wire logic                      rstN,
   input  wire logic                      clkEn,
   input  wire adct_pkg::adct_events_type events,
   input  wire logic [3:0]                sourceCode,
   input  wire logic                      sleepMode,
   input  wire logic                      sampling,
   output logic                           fire
);

   localparam logic [15:0] LAST_COUNT = 16'(SAMPLE_CYCLES - 1);

   logic [15:0] sampleCount;
   logic        autoExpired;

   ////////////////////////////////////////////////////////////////////////////
   // Counter restarts each time sampling begins
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         sampleCount <= 16'h0000;
      end else if (clkEn) begin
         if (!sampling || autoExpired) begin
            sampleCount <= 16'h0000;
         end else begin
            sampleCount <= sampleCount + 16'h0001;
         end
      end
   end

   assign autoExpired = sampling && (sampleCount == LAST_COUNT); // [R06]

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      fire = 1'b0;
      unique case (sourceCode)
         adct_pkg::SRC_CELL_TWO:     fire = events.cellTwo;       // [R01]
         adct_pkg::SRC_SINGLE_FOUR:  fire = events.singleFour;    // [R02]
         adct_pkg::SRC_MULTI_THREE:  fire = events.multiThree;    // [R03]
         adct_pkg::SRC_MULTI_TWO:    fire = events.multiTwo;      // [R04]
         adct_pkg::SRC_CELL_ONE:     fire = events.cellOne;       // [R05]
         adct_pkg::SRC_AUTO_COUNT:   fire = autoExpired;          // [R06]
         adct_pkg::SRC_TIMER_SLEEP:  fire = events.timerOneSleep; // [R07]
         adct_pkg::SRC_TIMER_ONE:    fire = events.timerOne;      // [R08]
         adct_pkg::SRC_CHARGE_TIME:  fire = events.chargeTime;    // [R09]
         adct_pkg::SRC_SINGLE_FIVE:  fire = events.singleFive;
         adct_pkg::SRC_MULTI_ONE:    fire = events.multiOne;      // [R10]
         adct_pkg::SRC_EXT_INT_ZERO: fire = events.extIntZero;    // [R11]
         default:                    fire = 1'b0;                 // [R16]
      endcase
      // Only the sleep-capable timer source may act while asleep
      if (sleepMode && (sourceCode != adct_pkg::SRC_TIMER_SLEEP)) begin
         fire = 1'b0; // [R12] [R13]
      end
   end

endmodule
`default_nettype wire

// *** hdl/adct_conversion_control.sv ***
// Converter control register, trigger sequencing and Wishbone slave
//
// Decided for this implementation: the register offsets and the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// R01 - Code 1100: logic cell two starts conversion
// R02 - Code 1011: single compare four starts conversion
// R03 - Code 1010: multi compare three starts conversion
// R04 - Code 1001: multi compare two starts conversion
// R05 - Code 1000: logic cell one starts conversion
// R06 - Code 0111: internal counter ends sampling automatically
// R07 - Code 0110: sleep-capable timer one starts conversion
// R08 - Code 0101: ordinary timer one starts conversion
// R09 - Code 0100: charge measurement unit starts conversion
// R10 - Code 0010: multi compare one starts conversion
// R11 - Code 0001: external interrupt zero starts conversion
// R12 - Sleep-capable timer trigger works during sleep
// R13 - Ordinary timer trigger never works during sleep
// R14 - On bit enables converter, cleared at reset
// R15 - Resolution bit and format field drive core
// R16 - Reserved codes 1101-1111 never start conversion
module adct_conversion_control #(
   parameter int SAMPLE_CYCLES = adct_pkg::AUTO_SAMPLE_CYCLES
) (
   input  wire logic                      clk,
   input  wire logic                      arst_n,
   input  wire logic                      clkEn,
   input  wire logic                      cyc_i,
   input  wire logic                      stb_i,
   input  wire logic                      we_i,
   input  wire logic [3:0]                adr_i,
   input  wire logic [3:0]                sel_i,
   input  wire logic [31:0]               dat_i,
   output logic      [31:0]               dat_o,
   output logic                           ack_o,
   input  wire adct_pkg::adct_events_type events,
   input  wire adct_pkg::adct_power_type  powerState,
   input  wire logic                      convDone,
   output logic                           convStart,
   output logic                           converterEnable,
   output logic                           resolution12,
   output logic      [1:0]                resultFormat,
   output logic                           sampleActive,
   output logic                           converting
);

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_SAMPLING,
      ST_CONVERTING
   } adct_state_type;

   logic                    rstSync1;
   logic                    rstSync2;
   logic                    rstN;
   adct_pkg::adct_ctrl_type ctrl;
   logic                    doneFlag;
   logic [15:0]             convCount;
   adct_state_type          state;
   adct_state_type          next_state;
   logic                    reqValid;
   logic                    wrTake;
   logic                    ctrlWrite;
   logic                    countWrite;
   logic [15:0]             ctrlWord;
   logic [15:0]             statusWord;
   logic [15:0]             mergedCtrl;
   logic                    sampleSet;
   logic                    sampleClear;
   logic                    doneClear;
   logic                    halted;
   logic                    fire;
   logic                    startNow;
   logic                    doneEvent;
   logic [31:0]             next_readData;

   ////////////////////////////////////////////////////////////////////////////
   // Helpers
   function automatic logic regHit(input logic [3:0] adr, input logic [3:0] offset);
      regHit = (adr[3:2] == offset[3:2]);
   endfunction

   function automatic logic [15:0] laneMerge(input logic [15:0] oldWord,
                                             input logic [15:0] newWord,
                                             input logic [1:0]  lanes);
      laneMerge = oldWord;
      if (lanes[0]) begin
         laneMerge[7:0] = newWord[7:0];
      end
      if (lanes[1]) begin
         laneMerge[15:8] = newWord[15:8];
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Reset release; runs free of clkEn so a frozen block still leaves reset
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rstSync1 <= 1'b0;
         rstSync2 <= 1'b0;
      end else begin
         rstSync1 <= 1'b1;
         rstSync2 <= rstSync1;
      end
   end

   assign rstN = rstSync2;

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode; a write lands on the edge that samples ack high
   assign reqValid   = cyc_i && stb_i && !ack_o;
   assign wrTake     = cyc_i && stb_i && we_i && ack_o;
   assign ctrlWrite  = wrTake && regHit(adr_i, adct_pkg::CTRL_OFFSET);
   assign countWrite = wrTake && regHit(adr_i, adct_pkg::COUNT_OFFSET);
   assign mergedCtrl = laneMerge(ctrlWord, dat_i[15:0], sel_i[1:0]);

   // Low-lane effects only when that lane is enabled
   assign sampleSet   = ctrlWrite && sel_i[0] && dat_i[adct_pkg::SAMPLE_BIT];
   assign sampleClear = ctrlWrite && sel_i[0] && !dat_i[adct_pkg::SAMPLE_BIT];
   assign doneClear   = ctrlWrite && sel_i[0] && !dat_i[adct_pkg::DONE_BIT];

   always_comb begin
      ctrlWord = adct_pkg::CTRL_RESET;
      ctrlWord[adct_pkg::ON_BIT]        = ctrl.converterOn;
      ctrlWord[adct_pkg::IDLE_STOP_BIT] = ctrl.stopWhenIdle;
      ctrlWord[adct_pkg::RES_BIT]       = ctrl.resolutionSelect;
      ctrlWord[adct_pkg::FMT_LSB+:2]    = ctrl.resultFormat;
      ctrlWord[adct_pkg::SRC_LSB+:4]    = ctrl.triggerSourceSelect;
      ctrlWord[adct_pkg::AUTO_BIT]      = ctrl.autoSample;
      ctrlWord[adct_pkg::SAMPLE_BIT]    = (state == ST_SAMPLING);
      ctrlWord[adct_pkg::DONE_BIT]      = doneFlag;
   end

   always_comb begin
      statusWord = 16'h0000;
      statusWord[adct_pkg::STAT_SAMPLING_BIT]   = (state == ST_SAMPLING);
      statusWord[adct_pkg::STAT_CONVERTING_BIT] = (state == ST_CONVERTING);
      statusWord[adct_pkg::STAT_HALTED_BIT]     = halted;
   end

   always_comb begin
      next_readData = 32'h0000_0000;
      if (regHit(adr_i, adct_pkg::CTRL_OFFSET)) begin
         next_readData[15:0] = ctrlWord;
      end else if (regHit(adr_i, adct_pkg::STATUS_OFFSET)) begin
         next_readData[15:0] = statusWord;
      end else if (regHit(adr_i, adct_pkg::COUNT_OFFSET)) begin
         next_readData[15:0] = convCount;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus answer: one cycle after the request, unmapped reads return zero
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         ack_o <= 1'b0;
      end else if (clkEn) begin
         ack_o <= reqValid;
      end
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         dat_o <= 32'h0000_0000;
      end else if (clkEn && reqValid) begin
         dat_o <= next_readData;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Software-owned control fields
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         ctrl <= '0; // [R14]
      end else if (clkEn && ctrlWrite) begin
         ctrl.converterOn         <= mergedCtrl[adct_pkg::ON_BIT]; // [R14]
         ctrl.stopWhenIdle        <= mergedCtrl[adct_pkg::IDLE_STOP_BIT];
         ctrl.resolutionSelect    <= mergedCtrl[adct_pkg::RES_BIT]; // [R15]
         ctrl.resultFormat        <= mergedCtrl[adct_pkg::FMT_LSB+:2]; // [R15]
         ctrl.triggerSourceSelect <= mergedCtrl[adct_pkg::SRC_LSB+:4];
         ctrl.autoSample          <= mergedCtrl[adct_pkg::AUTO_BIT];
      end
   end

   // Off, or idle with stop-in-idle set, halts sampling and conversion
   assign halted = !ctrl.converterOn
                || (powerState.idleMode && ctrl.stopWhenIdle); // [R14]

   ////////////////////////////////////////////////////////////////////////////
   // Trigger selection
   adct_trigger_select #(
      .SAMPLE_CYCLES (SAMPLE_CYCLES)
   ) triggerSelect (
      .clk        (clk),
      .rstN       (rstN),
      .clkEn      (clkEn),
      .events     (events),
      .sourceCode (ctrl.triggerSourceSelect),
      .sleepMode  (powerState.sleepMode),
      .sampling   (state == ST_SAMPLING),
      .fire       (fire)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Sample / convert sequencer
   always_comb begin
      next_state = state;
      startNow   = 1'b0;
      doneEvent  = 1'b0;
      unique case (state)
         ST_IDLE: begin
            if (!halted && (sampleSet || ctrl.autoSample)) begin
               next_state = ST_SAMPLING;
            end
         end
         ST_SAMPLING: begin
            if (halted) begin
               next_state = ST_IDLE;
            end else if (fire) begin
               next_state = ST_CONVERTING; // [R01] [R06] [R12]
               startNow   = 1'b1;
            end else if (sampleClear) begin
               // Manual end of sampling; no manual start while asleep
               if ((ctrl.triggerSourceSelect == adct_pkg::SRC_MANUAL)
                   && !powerState.sleepMode) begin
                  next_state = ST_CONVERTING;
                  startNow   = 1'b1;
               end else begin
                  next_state = ST_IDLE;
               end
            end
         end
         ST_CONVERTING: begin
            if (halted) begin
               // Abort: the core is told through converting going low
               next_state = ST_IDLE;
            end else if (convDone) begin
               doneEvent  = 1'b1;
               next_state = ctrl.autoSample ? ST_SAMPLING : ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         state <= ST_IDLE;
      end else if (clkEn) begin
         state <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Completion flag: a completion in the same cycle as a clear wins
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         doneFlag <= 1'b0;
      end else if (clkEn) begin
         doneFlag <= doneEvent || (doneFlag && !doneClear);
      end
   end

   // Completed conversions; a write clears, a same-cycle completion counts
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         convCount <= adct_pkg::COUNT_RESET;
      end else if (clkEn) begin
         if (countWrite) begin
            convCount <= {15'h0000, doneEvent};
         end else if (doneEvent) begin
            convCount <= convCount + 16'h0001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Converter core outputs
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         convStart    <= 1'b0;
         sampleActive <= 1'b0;
         converting   <= 1'b0;
      end else if (clkEn) begin
         convStart    <= startNow; // [R02] [R03] [R04] [R05] [R07]
         sampleActive <= (next_state == ST_SAMPLING);
         converting   <= (next_state == ST_CONVERTING);
      end
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         converterEnable <= 1'b0;
         resolution12    <= 1'b0;
         resultFormat    <= 2'h0;
      end else if (clkEn) begin
         converterEnable <= ctrl.converterOn;      // [R14]
         resolution12    <= ctrl.resolutionSelect; // [R15]
         resultFormat    <= ctrl.resultFormat;     // [R15]
      end
   end

endmodule
`default_nettype wire

// *** bench/adct_conversion_control_monitor.sv ***
// Port-level checker for the conversion trigger control block
`timescale 1ns/1ns
`default_nettype none
module adct_conversion_control_monitor #(
   parameter int SAMPLE_CYCLES = 20
) (
   input wire logic                      clk,
   input wire logic                      arst_n,
   input wire logic                      clkEn,
   input wire logic                      cyc_i,
   input wire logic                      stb_i,
   input wire logic                      we_i,
   input wire logic [3:0]                adr_i,
   input wire logic [3:0]                sel_i,
   input wire logic [31:0]               dat_i,
   input wire logic [31:0]               dat_o,
   input wire logic                      ack_o,
   input wire adct_pkg::adct_events_type events,
   input wire adct_pkg::adct_power_type  powerState,
   input wire logic                      convDone,
   input wire logic                      convStart,
   input wire logic                      converterEnable,
   input wire logic                      resolution12,
   input wire logic [1:0]                resultFormat,
   input wire logic                      sampleActive,
   input wire logic                      converting
);
   default clocking monClk @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   ////////////////////////////////////////////////////////////////////////////
   sequence reqTaken;
      cyc_i && stb_i && !ack_o && clkEn;
   endsequence

   sequence ctrlWrite;
      ack_o && we_i && adr_i[3:2] == 2'b00 && sel_i[1:0] == 2'b11 && clkEn;
   endsequence

   // Two cycles off, so the delayed enable copy has caught up with the halt
   sequence stayOff;
      !converterEnable && !$past(converterEnable);
   endsequence

   ////////////////////////////////////////////////////////////////////////////
   chk_ack_timely: assert property (reqTaken |=> ack_o)
      else $error("request taken without acknowledge");
   chk_ack_single: assert property (ack_o |=> !ack_o)
      else $error("acknowledge longer than one cycle");
   chk_upper_zero: assert property (ack_o |-> dat_o[31:16] == 16'h0000)
      else $error("read data upper half not zero");
   chk_ctrl_outputs: assert property (ctrlWrite |-> ##2
      (converterEnable == $past(dat_i[15], 2) && resolution12 == $past(dat_i[10], 2)
       && resultFormat == $past(dat_i[9:8], 2)))
      else $error("control outputs do not follow written word");
   chk_start_pulse: assert property (convStart |=> !convStart)
      else $error("start pulse longer than one cycle");
   chk_start_enters: assert property ($rose(converting) |-> convStart && !sampleActive)
      else $error("conversion entered without start pulse");
   chk_sleep_source: assert property (convStart && $past(powerState.sleepMode)
      && $past(clkEn) |-> $past(events.timerOneSleep))
      else $error("start in sleep without sleep timer event");
   chk_done_ends: assert property (converting && convDone && clkEn |=> !converting)
      else $error("conversion outlived done");
   chk_halt_idle: assert property (stayOff |-> !sampleActive && !converting)
      else $error("activity while converter off");
   chk_states_apart: assert property (!(sampleActive && converting))
      else $error("sampling and converting together");
endmodule

bind adct_conversion_control adct_conversion_control_monitor #(
   .SAMPLE_CYCLES(SAMPLE_CYCLES)
) monitor (
   .clk(clk), .arst_n(arst_n), .clkEn(clkEn), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
   .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
   .events(events), .powerState(powerState), .convDone(convDone), .convStart(convStart),
   .converterEnable(converterEnable), .resolution12(resolution12),
   .resultFormat(resultFormat), .sampleActive(sampleActive), .converting(converting)
);
`default_nettype wire

// *** bench/adct_conversion_control_tb.sv ***
// Self-checking bench for the conversion trigger control block
`timescale 1ns/1ns
`default_nettype none
module adct_conversion_control_tb;
   localparam int             NSAMP = 8;
   localparam int             LIMIT = 6000;
   localparam logic [3:0]     CTRL  = adct_pkg::CTRL_OFFSET;
   localparam logic [3:0]     STAT  = adct_pkg::STATUS_OFFSET;
   localparam logic [3:0]     CNT   = adct_pkg::COUNT_OFFSET;
   logic                      clk = 1'b0;
   logic                      arst_n = 1'b0;
   logic                      clkEn = 1'b1;
   logic                      cyc = 1'b0;
   logic                      stb = 1'b0;
   logic                      we = 1'b0;
   logic [3:0]                adr = 4'h0;
   logic [3:0]                sel = 4'h0;
   logic [31:0]               wdat = 32'h0;
   adct_pkg::adct_events_type events = '0;
   adct_pkg::adct_power_type  power = '0;
   logic                      done = 1'b0;
   logic [31:0]               rdat;
   logic                      ack;
   logic                      convStart;
   logic                      converterEnable;
   logic                      resolution12;
   logic [1:0]                resultFormat;
   logic                      sampleActive;
   logic                      converting;
   int                        failCount = 0;
   int                        checkCount = 0;
   int                        starts = 0;
   int                        cycles = 0;

   adct_conversion_control #(
      .SAMPLE_CYCLES(NSAMP)
   ) uut (
      .clk(clk), .arst_n(arst_n), .clkEn(clkEn), .cyc_i(cyc), .stb_i(stb), .we_i(we),
      .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .events(events),
      .powerState(power), .convDone(done), .convStart(convStart),
      .converterEnable(converterEnable), .resolution12(resolution12),
      .resultFormat(resultFormat), .sampleActive(sampleActive), .converting(converting)
   );

   always #5 clk = ~clk;

   // Start pulses are counted here so a pulse is never missed between task calls
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (convStart === 1'b1) begin
         starts <= starts + 1;
      end
      if (cycles == LIMIT) begin
         failCount++;
         conclude();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic conclude();
      if (failCount == 0 && checkCount > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checkCount++;
      if (seen !== exp) begin
         failCount++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d,
                      output logic [31:0] q);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'h3;
      wdat <= {16'h0000, d};
      do @(posedge clk); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rdchk(input string what, input logic [3:0] a, input logic [15:0] e);
      logic [31:0] q;
      bus(1'b0, a, 16'h0000, q);
      check(what, q, {16'h0000, e});
   endtask

   task automatic pulse(input logic [10:0] v);
      @(posedge clk);
      events <= adct_pkg::adct_events_type'(v);
      @(posedge clk);
      events <= '0;
      repeat (4) @(posedge clk);
   endtask

   // Every other source fires first, so a wrong selection shows up as a start
   task automatic trig(input logic [3:0] code, input int bitn, input logic slp, input int exp);
      logic [10:0] hit;
      int          s0;
      hit = 11'h001 << bitn;
      // The on bit must already stand when sampling is requested
      wr(CTRL, 16'h8000 | {8'h00, code, 4'h0});
      wr(CTRL, 16'h8002 | {8'h00, code, 4'h0});
      @(posedge clk);
      power <= {slp, 1'b0};
      s0 = starts;
      check("sampling before event", sampleActive, 1);
      pulse(~hit);
      check("start on other events", starts - s0, 0);
      pulse(hit);
      check("start on selected event", starts - s0, exp);
      check("converting after event", converting, exp);
      @(posedge clk);
      done <= 1'b1;
      @(posedge clk);
      done <= 1'b0;
      power <= '0;
      wr(CTRL, 16'h0000);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      int n;
      int s0;
      repeat (4) @(posedge clk);
      arst_n <= 1'b1;
      repeat (4) @(posedge clk);
      rdchk("control reset", CTRL, 16'h0000);
      rdchk("status reset", STAT, 16'h0004);
      rdchk("unmapped read", 4'hc, 16'h0000);
      wr(CTRL, 16'hffd8);
      rdchk("control readback", CTRL, 16'ha7d0);
      check("converter enable on", converterEnable, 1);
      check("resolution twelve", resolution12, 1);
      check("result format", resultFormat, 3);
      wr(4'hc, 16'hffff);
      wr(STAT, 16'hffff);
      rdchk("status after write", STAT, 16'h0000);
      rdchk("control kept", CTRL, 16'ha7d0);
      wr(CTRL, 16'h2000);
      rdchk("control off", CTRL, 16'h2000);
      check("converter enable off", converterEnable, 0);
      check("resolution ten", resolution12, 0);
      trig(4'hc, 9, 1'b0, 1);
      trig(4'hb, 8, 1'b0, 1);
      trig(4'ha, 4, 1'b0, 1);
      trig(4'h9, 5, 1'b0, 1);
      trig(4'h8, 10, 1'b0, 1);
      trig(4'h6, 2, 1'b0, 1);
      trig(4'h5, 3, 1'b0, 1);
      trig(4'h4, 1, 1'b0, 1);
      trig(4'h2, 6, 1'b0, 1);
      trig(4'h1, 0, 1'b0, 1);
      trig(4'h6, 2, 1'b1, 1);
      trig(4'h5, 3, 1'b1, 0);
      trig(4'hd, 0, 1'b0, 0);
      trig(4'he, 0, 1'b0, 0);
      trig(4'hf, 0, 1'b0, 0);
      wr(CTRL, 16'h8070);
      wr(CTRL, 16'h8072);
      n = 0;
      s0 = starts;
      while (starts == s0 && n < 40) begin
         @(posedge clk);
         n++;
      end
      check("auto-convert delay", (n >= NSAMP && n <= NSAMP + 5), 1);
      @(posedge clk);
      done <= 1'b1;
      @(posedge clk);
      done <= 1'b0;
      wr(CTRL, 16'h0000);
      rdchk("conversion count", CNT, 16'h000c);
      conclude();
   end
endmodule
`default_nettype wire
